// [bench/sensor_model.sv]
// modulator code source standing in for the bridge and temperature front ends
module sensor_model (
  input  wire logic       clk_sys,
  input  wire logic [2:0] pCode,
  input  wire logic [2:0] tCode,
  output logic [2:0]      pModBits,
  output logic [2:0]      tModBits
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // modulator outputs
  // codes move only just after an edge, so the sampling tick never sees a half-changed code
  always_ff @(posedge clk_sys) begin
    pModBits <= pCode;
    tModBits <= tCode;
  end
endmodule : sensor_model

// [bench/tb_bridge_temp_adc_readout.sv]
// self-checking bench: register access, conversion results and result fifo
module tb_bridge_temp_adc_readout
  import adc_readout_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [31:0] REF = 32'h1 << BIT_STS_REF;
  localparam logic [31:0] NE  = 32'h1 << BIT_STS_FIFO_NE;
  localparam logic [31:0] OVF = 32'h1 << BIT_STS_FIFO_OVF;
  // gain code taken as the 5 V/V setting; the code is arbitrary
  localparam logic [31:0] T_GAIN_5VV = 32'h1;

  logic        clk_sys, rst_b, cyc, stb, we, ack;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] datW, datR, rd;
  logic [2:0]  pCode, tCode, pModBits, tModBits;
  analog_cfg_t analogCfg;
  logic        refValid, pResultValid, tResultValid;
  logic [23:0] pResult, tResult;
  int          num_errors, n_checks, cycCnt, relAt, tA, tB;

  sensor_model model_u (.clk_sys(clk_sys), .pCode(pCode), .tCode(tCode), .pModBits(pModBits), .tModBits(tModBits));

  bridge_temp_adc_readout #(.FIFO_DEPTH(8)) dut_u (
    .clk_sys(clk_sys), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(datW), .wb_dat_o(datR), .wb_ack_o(ack), .pModBits(pModBits),
    .tModBits(tModBits), .analogCfg(analogCfg), .refValid(refValid), .pResultValid(pResultValid),
    .pResult(pResult), .tResultValid(tResultValid), .tResult(tResult)
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) cycCnt <= cycCnt + 1;

  // ==========================================================
  // helpers
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // request held until ack is sampled at an edge, released at that edge
  task automatic wb_io(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_sys);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    datW <= d;
    @(posedge clk_sys);
    while (ack !== 1'b1 && n < 20) begin
      @(posedge clk_sys);
      n++;
    end
    q = datR;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20) begin
      num_errors++;
      finish_test();
    end
  endtask : wb_io

  // the pause lets the configuration outputs follow the write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb_io(1'b1, a, d, rd);
    repeat (3) @(posedge clk_sys);
  endtask : wr

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    wb_io(1'b0, a, 32'h0, rd);
    check(nm, rd & m, e);
  endtask : rchk

  task automatic wait_strobe(output int at);
    int n;
    n = 0;
    @(posedge clk_sys);
    while (pResultValid !== 1'b1 && n < 13000) begin
      @(posedge clk_sys);
      n++;
    end
    at = cycCnt;
    if (n >= 13000) begin
      num_errors++;
      finish_test();
    end else begin
      check("tStrobe", 32'(tResultValid), 32'h1);
      @(posedge clk_sys);
      check("pStrobeLow", 32'(pResultValid), 32'h0);
    end
  endtask : wait_strobe

  // ==========================================================
  // main sequence
  initial begin
    rst_b = 1'b0;
    {cyc, stb, we} = 3'h0;
    adr = 8'h00;
    sel = 4'hf;
    datW = 32'h0;
    pCode = 3'h7;
    tCode = 3'h0;
    num_errors = 0;
    n_checks = 0;
    cycCnt = 0;
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    relAt = cycCnt;
    check("cfgAtReset", 32'(analogCfg), 32'h0);
    rchk("power", OFS_ANALOG_POWER, 32'hffffffff, RST_ANALOG_POWER);
    wr(OFS_ANALOG_POWER, 32'h1);
    check("refBufOn", 32'(analogCfg.refBufEnable), 32'h1);
    wr(OFS_ANALOG_POWER, 32'h0);
    check("refBufOff", 32'(analogCfg.refBufEnable), 32'h0);
    for (int i = 0; i < 3; i++) begin
      wr(OFS_BRIDGE_CTRL, 32'(i) | 32'h4);
      check("bridgeLevel", 32'(analogCfg.bridgeLevel), 32'(i));
      check("bridgeSwOn", 32'(analogCfg.bridgeSwitchOn), 32'h1);
    end
    wr(OFS_BRIDGE_CTRL, 32'h3);
    check("bridgeLvl3", 32'(analogCfg.bridgeLevel), 32'(BRIDGE_1V25));
    check("bridgeSwOff", 32'(analogCfg.bridgeSwitchOn), 32'h0);
    wr(OFS_TEMP_CTRL, 32'h1f);
    check("tempCurrent", 32'(analogCfg.tempCurrent), 32'hf);
    check("tempSrcExt", 32'(analogCfg.tempSrcExternal), 32'h1);
    wr(OFS_P_GAIN, 32'h1f);
    sel <= 4'he;
    wr(OFS_P_GAIN, 32'h00);
    sel <= 4'hf;
    check("pGain", 32'(analogCfg.pGain), 32'h1f);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_T_GAIN, 32'(i));
      check("tGain", 32'(analogCfg.tGain), 32'(i));
    end
    // external sensor with neither end grounded: differential
    wr(OFS_MUX_CTRL, 32'h1);
    check("seN", 32'(analogCfg.tempSingleEndedN), 32'h1);
    // internal sensor: single-ended at the 5 V/V gain code
    wr(OFS_TEMP_CTRL, 32'h0);
    wr(OFS_MUX_CTRL, 32'h0);
    wr(OFS_T_GAIN, T_GAIN_5VV);
    check("tempSrcInt", 32'(analogCfg.tempSrcExternal), 32'h0);
    check("seMode", 32'(analogCfg.tempSingleEndedN), 32'h0);
    check("tGain5", 32'(analogCfg.tGain), T_GAIN_5VV);
    wr(8'h3c, 32'hffffffff);
    rchk("unmapped", 8'h3c, 32'hffffffff, 32'h0);
    $display("test configuration done");
    while (cycCnt - relAt < 4990) @(posedge clk_sys);
    check("refEarly", 32'(refValid), 32'h0);
    while (cycCnt - relAt < 5010) @(posedge clk_sys);
    check("refLate", 32'(refValid), 32'h1);
    rchk("stsRef", OFS_STATUS, REF, REF);
    $display("test reference done");
    wait_strobe(tA);
    wait_strobe(tA);
    wait_strobe(tB);
    check("period", 32'(tB - tA), 32'(OSR * MOD_DIV_CYCLES));
    check("pFullPos", 32'(pResult), 32'h7fffff);
    check("tFullNeg", 32'(tResult), 32'h800000);
    rchk("pReg", OFS_P_RESULT, 32'hffffff, 32'h7fffff);
    rchk("tMid", OFS_TEMP_RES_MID, 32'hffff, 32'h0);
    rchk("tHigh", OFS_TEMP_RES_HIGH, 32'hff, 32'h80);
    $display("test results done");
    // fifo left unread: four periods fill it, the fifth overflows
    wait_strobe(tA);
    wait_strobe(tA);
    pCode <= 3'h0;
    tCode <= 3'h7;
    rchk("stsFull", OFS_STATUS, NE | OVF, NE | OVF);
    for (int i = 0; i < 8; i++) begin
      rchk("fifoPop", OFS_FIFO_DATA, 32'h80ffffff, (i % 2) ? 32'h80800000 : 32'h007fffff);
    end
    rchk("stsEmpty", OFS_STATUS, NE, 32'h0);
    wr(OFS_STATUS, OVF);
    rchk("ovfClear", OFS_STATUS, OVF, 32'h0);
    $display("test fifo done");
    wait_strobe(tA);
    wait_strobe(tA);
    check("pFullNeg", 32'(pResult), 32'h800000);
    check("tFullPos", 32'(tResult), 32'h7fffff);
    rchk("tMid2", OFS_TEMP_RES_MID, 32'hffff, 32'hffff);
    rchk("tHigh2", OFS_TEMP_RES_HIGH, 32'hff, 32'h7f);
    $display("test reversed inputs done");
    finish_test();
  end
endmodule : tb_bridge_temp_adc_readout

// [rtl/adc_readout_pkg.sv]
// package: register map, field layout, timing constants and carriers for the readout block
package adc_readout_pkg;

  // ==========================================================
  // timing
  localparam int unsigned CLK_FREQ_HZ      = 100_000_000;
  localparam int unsigned REF_VALID_US     = 50;
  localparam int unsigned CONV_PERIOD_US   = 128;
  localparam int unsigned MOD_RATE_HZ      = 1_000_000;
  localparam int unsigned REF_VALID_CYCLES = REF_VALID_US * (CLK_FREQ_HZ / 1_000_000);
  localparam int unsigned MOD_DIV_CYCLES   = CLK_FREQ_HZ / MOD_RATE_HZ;
  localparam int unsigned OSR              = CONV_PERIOD_US * MOD_RATE_HZ / 1_000_000;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_ANALOG_POWER  = 8'h00;
  localparam logic [7:0] OFS_BRIDGE_CTRL   = 8'h04;
  localparam logic [7:0] OFS_TEMP_CTRL     = 8'h08;
  localparam logic [7:0] OFS_P_GAIN        = 8'h0c;
  localparam logic [7:0] OFS_T_GAIN        = 8'h10;
  localparam logic [7:0] OFS_MUX_CTRL      = 8'h14;
  localparam logic [7:0] OFS_STATUS        = 8'h18;
  localparam logic [7:0] OFS_P_RESULT      = 8'h1c;
  localparam logic [7:0] OFS_TEMP_RES_MID  = 8'h20;
  localparam logic [7:0] OFS_TEMP_RES_HIGH = 8'h24;
  localparam logic [7:0] OFS_FIFO_DATA     = 8'h28;

  // ==========================================================
  // field positions and reset values
  localparam int unsigned BIT_REF_BUF_EN   = 0;
  localparam int unsigned BIT_BRIDGE_SW    = 2;
  localparam int unsigned BIT_TEMP_SE_N    = 0;
  localparam int unsigned BIT_TEMP_SRC     = 4;
  localparam int unsigned BIT_STS_REF      = 0;
  localparam int unsigned BIT_STS_FIFO_NE  = 1;
  localparam int unsigned BIT_STS_FIFO_OVF = 2;
  localparam logic [31:0] RST_ANALOG_POWER = 32'h0000_0000;
  localparam logic [1:0]  RST_BRIDGE_SEL   = 2'h0;
  localparam logic [4:0]  RST_P_GAIN       = 5'h00;
  localparam logic [1:0]  RST_T_GAIN       = 2'h0;
  localparam logic [3:0]  RST_TEMP_CURRENT = 4'h0;

  typedef enum logic [1:0] {
    BRIDGE_2V5  = 2'h0,
    BRIDGE_2V0  = 2'h1,
    BRIDGE_1V25 = 2'h2
  } bridge_level_t;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic          refBufEnable;
    bridge_level_t bridgeLevel;
    logic          bridgeSwitchOn;
    logic [3:0]    tempCurrent;
    logic          tempSrcExternal;
    logic          tempSingleEndedN;
    logic [4:0]    pGain;
    logic [1:0]    tGain;
  } analog_cfg_t;

  typedef struct packed {
    logic        isTemp;
    logic [23:0] code;
  } sample_t;

endpackage : adc_readout_pkg

// [rtl/bridge_temp_adc_readout.sv]
// bridge and temperature conversion chains with wishbone register access
//
// The register offsets and the Wishbone interface to the registers were chosen for this implementation.
module bridge_temp_adc_readout
  import adc_readout_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = 8
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [2:0]  pModBits,
  input  wire logic [2:0]  tModBits,
  output analog_cfg_t      analogCfg,
  output logic             refValid,
  output logic             pResultValid,
  output logic [23:0]      pResult,
  output logic             tResultValid,
  output logic [23:0]      tResult
);
  localparam int unsigned ACC_W  = 32;
  localparam int unsigned REF_CW = $clog2(REF_VALID_CYCLES + 1);
  localparam int unsigned DIV_CW = $clog2(MOD_DIV_CYCLES);
  localparam int unsigned OSR_CW = $clog2(OSR);
  localparam int unsigned GAP_CW = $clog2(OSR * MOD_DIV_CYCLES);
  // largest magnitude a full period of levels can sum to
  localparam int          FULL_SUM = int'(OSR) * 7;

  // ==========================================================
  // helpers
  // modulator codes 0..7 map to signed levels -7..+7 in steps of 2
  function automatic logic signed [ACC_W-1:0] modLevel(input logic [2:0] code);
    modLevel = ACC_W'(signed'({1'b0, code, 1'b0})) - ACC_W'(signed'(5'sd7));
  endfunction : modLevel

  // map a sum of OSR levels onto the 24-bit code range; the negative side
  // reaches one code further, as two's complement does
  function automatic logic [23:0] toCode(input logic signed [ACC_W-1:0] acc);
    logic signed [ACC_W+7:0] scaled;
    scaled = (ACC_W+8)'(acc) * ((acc < 0) ? (ACC_W+8)'(8388608) : (ACC_W+8)'(8388607));
    scaled = scaled / (ACC_W+8)'(FULL_SUM);
    // clamp kept so a wider level set cannot wrap the code
    if (scaled > (ACC_W+8)'(8388607)) begin
      toCode = 24'h7fffff;
    end else if (scaled < -(ACC_W+8)'(8388608)) begin
      toCode = 24'h800000;
    end else begin
      toCode = scaled[23:0];
    end
  endfunction : toCode

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] din, input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[8*i +: 8] = din[8*i +: 8];
      end
    end
    merge = res;
  endfunction : merge

  // ==========================================================
  // reference valid timer
  logic [REF_CW-1:0] refCount;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      refCount <= '0;
      refValid <= 1'b0;
    end else if (!refValid) begin
      refCount <= refCount + 1'b1;
      refValid <= (refCount == REF_CW'(REF_VALID_CYCLES - 1));
    end
  end

  // ==========================================================
  // modulator sampling tick and decimators
  logic [DIV_CW-1:0] divCount;
  logic              modTick;
  logic [OSR_CW-1:0] osrCount;
  logic signed [ACC_W-1:0] pAcc;
  logic signed [ACC_W-1:0] tAcc;
  logic              convDone;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      divCount <= '0;
      modTick  <= 1'b0;
    end else begin
      divCount <= (divCount == DIV_CW'(MOD_DIV_CYCLES - 1)) ? '0 : divCount + 1'b1;
      modTick  <= (divCount == DIV_CW'(MOD_DIV_CYCLES - 1));
    end
  end

  assign convDone = modTick && (osrCount == OSR_CW'(OSR - 1));

  // 1 MHz sample of 3-bit modulator codes
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      osrCount <= '0;
      pAcc     <= '0;
      tAcc     <= '0;
    end else if (modTick) begin
      osrCount <= convDone ? '0 : osrCount + 1'b1;
      // the closing sample belongs to the result just latched, so the next sum starts empty
      pAcc     <= convDone ? '0 : pAcc + modLevel(pModBits);
      tAcc     <= convDone ? '0 : tAcc + modLevel(tModBits);
    end
  end

  // latch signed results, strobe once per period
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pResult      <= '0;
      tResult      <= '0;
      pResultValid <= 1'b0;
      tResultValid <= 1'b0;
    end else begin
      pResultValid <= convDone;
      tResultValid <= convDone;
      if (convDone) begin
        pResult <= toCode(pAcc + modLevel(pModBits));
        // linear code law is carried by the analog scaling
        tResult <= toCode(tAcc + modLevel(tModBits));
      end
    end
  end

  // ==========================================================
  // result fifo; overflow counts as a sticky status bit
  sample_t fifoIn;
  sample_t fifoOut;
  logic    fifoInValid;
  logic    fifoInReady;
  logic    fifoOutValid;
  logic    fifoPop;
  logic    fifoOverflow;
  logic    pendTemp;

  // pressure enters on the strobe, temperature on the cycle after
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pendTemp <= 1'b0;
    end else begin
      pendTemp <= pResultValid;
    end
  end
  assign fifoInValid = pResultValid || pendTemp;
  assign fifoIn      = pendTemp ? sample_t'{isTemp: 1'b1, code: tResult} : sample_t'{isTemp: 1'b0, code: pResult};

  sample_fifo #(
    .WIDTH ($bits(sample_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .inData   (fifoIn),
    .inValid  (fifoInValid),
    .inReady  (fifoInReady),
    .outData  (fifoOut),
    .outValid (fifoOutValid),
    .outReady (fifoPop)
  );

  // ==========================================================
  // wishbone slave, single-cycle ack
  logic busReq;
  logic busWr;
  logic busRd;
  logic [31:0] powerReg;
  logic [31:0] bridgeReg;
  logic [31:0] tempReg;
  logic [31:0] pGainReg;
  logic [31:0] tGainReg;
  logic [31:0] muxReg;
  logic [31:0] next_rdData;

  assign busReq  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign busWr   = busReq && wb_we_i;
  assign busRd   = busReq && !wb_we_i;
  assign fifoPop = busRd && (wb_adr_i == OFS_FIFO_DATA) && fifoOutValid;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      powerReg  <= RST_ANALOG_POWER;
      bridgeReg <= 32'h0000_0000;
      tempReg   <= 32'h0000_0000;
      pGainReg  <= 32'h0000_0000;
      tGainReg  <= 32'h0000_0000;
      muxReg    <= 32'h0000_0000;
    end else if (busWr) begin
      unique case (wb_adr_i)
        OFS_ANALOG_POWER: powerReg  <= merge(powerReg, wb_dat_i, wb_sel_i) & 32'h0000_0001;
        OFS_BRIDGE_CTRL:  bridgeReg <= merge(bridgeReg, wb_dat_i, wb_sel_i) & 32'h0000_0007;
        OFS_TEMP_CTRL:    tempReg   <= merge(tempReg, wb_dat_i, wb_sel_i) & 32'h0000_001f;
        OFS_P_GAIN:       pGainReg  <= merge(pGainReg, wb_dat_i, wb_sel_i) & 32'h0000_001f;
        OFS_T_GAIN:       tGainReg  <= merge(tGainReg, wb_dat_i, wb_sel_i) & 32'h0000_0003;
        OFS_MUX_CTRL:     muxReg    <= merge(muxReg, wb_dat_i, wb_sel_i) & 32'h0000_0001;
        default: ;
      endcase
    end
  end

  // overflow: a dropped sample sets, a status write of one clears; set wins
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      fifoOverflow <= 1'b0;
    end else if (fifoInValid && !fifoInReady) begin
      fifoOverflow <= 1'b1;
    end else if (busWr && wb_adr_i == OFS_STATUS && wb_sel_i[0] && wb_dat_i[BIT_STS_FIFO_OVF]) begin
      fifoOverflow <= 1'b0;
    end
  end

  always_comb begin
    next_rdData = 32'h0000_0000;
    unique case (wb_adr_i)
      OFS_ANALOG_POWER:  next_rdData = powerReg;
      OFS_BRIDGE_CTRL:   next_rdData = bridgeReg;
      OFS_TEMP_CTRL:     next_rdData = tempReg;
      OFS_P_GAIN:        next_rdData = pGainReg;
      OFS_T_GAIN:        next_rdData = tGainReg;
      OFS_MUX_CTRL:      next_rdData = muxReg;
      OFS_STATUS:        next_rdData = {29'h0, fifoOverflow, fifoOutValid, refValid};
      OFS_P_RESULT:      next_rdData = {8'h00, pResult};
      // temperature result split over two registers
      OFS_TEMP_RES_MID:  next_rdData = {16'h0000, tResult[15:0]};
      OFS_TEMP_RES_HIGH: next_rdData = {24'h000000, tResult[23:16]};
      OFS_FIFO_DATA:     next_rdData = fifoOutValid ? {fifoOut.isTemp, 7'h00, fifoOut.code} : 32'h0000_0000;
      default:           next_rdData = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= busReq;
      wb_dat_o <= busRd ? next_rdData : 32'h0000_0000;
    end
  end

  // ==========================================================
  // analog configuration outputs
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      analogCfg <= '{refBufEnable: 1'b0, bridgeLevel: BRIDGE_2V5, bridgeSwitchOn: 1'b0,
                     tempCurrent: RST_TEMP_CURRENT, tempSrcExternal: 1'b0, tempSingleEndedN: 1'b0,
                     pGain: RST_P_GAIN, tGain: RST_T_GAIN};
    end else begin
      analogCfg.refBufEnable     <= powerReg[BIT_REF_BUF_EN];
      analogCfg.bridgeLevel      <= (bridgeReg[1:0] == 2'h3) ? BRIDGE_1V25 : bridge_level_t'(bridgeReg[1:0]);
      analogCfg.bridgeSwitchOn   <= bridgeReg[BIT_BRIDGE_SW];
      analogCfg.tempCurrent      <= tempReg[3:0];
      analogCfg.tempSrcExternal  <= tempReg[BIT_TEMP_SRC];
      analogCfg.tempSingleEndedN <= muxReg[BIT_TEMP_SE_N];
      analogCfg.pGain            <= pGainReg[4:0];
      analogCfg.tGain            <= tGainReg[1:0];
    end
  end

  // ==========================================================
  // assertion helpers
  // independent cycle counts, so the rate checks do not lean on the design's own counters
  logic [DIV_CW-1:0] tickGap;
  logic              tickSeen;
  logic [GAP_CW-1:0] strobeGap;
  logic              strobeSeen;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tickGap  <= '0;
      tickSeen <= 1'b0;
    end else begin
      tickGap  <= modTick ? '0 : tickGap + 1'b1;
      tickSeen <= tickSeen || modTick;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      strobeGap  <= '0;
      strobeSeen <= 1'b0;
    end else begin
      strobeGap  <= pResultValid ? '0 : strobeGap + 1'b1;
      strobeSeen <= strobeSeen || pResultValid;
    end
  end

  // ==========================================================
  // checks
  refHold_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    refValid |=> refValid) else $error("reference valid dropped");
  refEarly_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (refCount < REF_CW'(REF_VALID_CYCLES - 1)) |-> !refValid) else $error("reference valid too early");
  strobeOne_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    pResultValid |=> !pResultValid) else $error("result strobe longer than one cycle");
  strobePair_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    pResultValid == tResultValid) else $error("chains out of step");
  convPeriod_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    pResultValid |=> !pResultValid [*8] ##1 !pResultValid [*8]) else $error("results too close");
  modRate_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    tickSeen |-> (modTick == (tickGap == DIV_CW'(MOD_DIV_CYCLES - 1))))
    else $error("modulator tick rate wrong");
  resultGap_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    strobeSeen |-> (pResultValid == (strobeGap == GAP_CW'(OSR * MOD_DIV_CYCLES - 1))))
    else $error("result period wrong");
  refCfg_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (busWr && wb_adr_i == OFS_ANALOG_POWER && wb_sel_i[0]) |=> ##1
    (analogCfg.refBufEnable == $past(wb_dat_i[BIT_REF_BUF_EN], 2))) else $error("buffer enable not applied");
  pGainCfg_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (busWr && wb_adr_i == OFS_P_GAIN && wb_sel_i[0]) |=> ##1
    (analogCfg.pGain == $past(wb_dat_i[4:0], 2))) else $error("pressure gain not applied");
  tempSplit_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (busRd && wb_adr_i == OFS_TEMP_RES_HIGH) |=> (wb_dat_o[7:0] == $past(tResult[23:16])))
    else $error("temp high wrong");
  ackOnce_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
  ackQuiet_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !wb_ack_o |-> (wb_dat_o == 32'h0000_0000)) else $error("read data outside ack");
  pHold_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !pResultValid |-> $stable(pResult)) else $error("pressure result moved without strobe");
  tHold_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !tResultValid |-> $stable(tResult)) else $error("temperature result moved without strobe");
  bridgeLegal_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    analogCfg.bridgeLevel != bridge_level_t'(2'h3)) else $error("bridge level code unused");
  bridgeSw_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (busWr && wb_adr_i == OFS_BRIDGE_CTRL && wb_sel_i[0]) |=> ##1
    (analogCfg.bridgeSwitchOn == $past(wb_dat_i[BIT_BRIDGE_SW], 2))) else $error("bridge switch not applied");
  tempCur_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (busWr && wb_adr_i == OFS_TEMP_CTRL && wb_sel_i[0]) |=> ##1
    (analogCfg.tempCurrent == $past(wb_dat_i[3:0], 2))) else $error("current setting not applied");
  tempSrc_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (busWr && wb_adr_i == OFS_TEMP_CTRL && wb_sel_i[0]) |=> ##1
    (analogCfg.tempSrcExternal == $past(wb_dat_i[BIT_TEMP_SRC], 2))) else $error("source not applied");
  tGainCfg_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (busWr && wb_adr_i == OFS_T_GAIN && wb_sel_i[0]) |=> ##1
    (analogCfg.tGain == $past(wb_dat_i[1:0], 2))) else $error("temperature gain not applied");
  seMode_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (busWr && wb_adr_i == OFS_MUX_CTRL && wb_sel_i[0]) |=> ##1
    (analogCfg.tempSingleEndedN == $past(wb_dat_i[BIT_TEMP_SE_N], 2))) else $error("mode not applied");
  ovfSet_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (fifoInValid && !fifoInReady) |=> fifoOverflow) else $error("dropped sample not flagged");

  resultSeen_c: cover property (@(posedge clk_sys) disable iff (!rst_b) pResultValid);
  fifoFull_c: cover property (@(posedge clk_sys) disable iff (!rst_b) !fifoInReady);
  fifoOvf_c: cover property (@(posedge clk_sys) disable iff (!rst_b) fifoOverflow);
  fifoPop_c: cover property (@(posedge clk_sys) disable iff (!rst_b) fifoPop);
  ovfClear_c: cover property (@(posedge clk_sys) disable iff (!rst_b) $fell(fifoOverflow));
endmodule : bridge_temp_adc_readout

// [rtl/sample_fifo.sv]
// synchronous fifo with valid/ready on both sides
module sample_fifo #(
  parameter int unsigned WIDTH = 25,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic [WIDTH-1:0]      outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW:0]      count;
  logic             doWr;
  logic             doRd;

  assign inReady  = (count != (AW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign outData  = mem[rdPtr];
  assign doWr     = inValid && inReady;
  assign doRd     = outValid && outReady;

  always_ff @(posedge clk_sys) begin
    if (doWr) begin
      mem[wrPtr] <= inData;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (doWr) begin
        wrPtr <= (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
      end
      if (doRd) begin
        rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
      end
      count <= count + (AW+1)'(doWr) - (AW+1)'(doRd);
    end
  end
endmodule : sample_fifo
